/* File: pkg/uart_hd_map.vh */
// register map, field positions, reset values and timing constants of the half-duplex uart
`ifndef UART_HD_MAP_VH
`define UART_HD_MAP_VH
// byte addresses (printed offsets are not multiples of four: index times four)
`define DATA_PORT_IDX    8'hd6
`define CTRL_STAT_IDX    8'hd7
`define IRQ_STATUS_IDX   8'hd8
`define IRQ_ENABLE_IDX   8'hd9
`define IRQ_CLEAR_IDX    8'hda
// control/status fields
`define RX_READY_BIT     7
`define TX_EMPTY_BIT     6
`define RX_IRQ_EN_BIT    5
`define TX_IRQ_EN_BIT    4
`define BAUD_MSB         3
`define BAUD_LSB         1
`define NINTH_BIT        0
`define CTRL_RESET       8'h00
// irq status bits
`define EV_RX_DONE       0
`define EV_TX_DONE       1
`define EV_RX_ABORT      2
// divisors of the internal clock per bit time, codes 000..110
`define DIV_0            13'd6656
`define DIV_1            13'd3328
`define DIV_2            13'd1664
`define DIV_3            13'd832
`define DIV_4            13'd416
`define DIV_5            13'd256
`define DIV_6            13'd208
// oversampling: eight states per bit, votes at states 3,4,5
`define STATES_PER_BIT   3'd7
`define VOTE_A           3'd3
`define VOTE_B           3'd4
`define VOTE_C           3'd5
`define FRAME_DATA_BITS  4'd9
// bit slots of a frame: 0 start, 1..9 data, 10 stop
`define NINTH_SLOT       4'd9
`define FRAME_LAST_SLOT  4'd10
`endif

/* File: hdl/uart_hd.v */
// half-duplex uart with baud divider, receive buffer and avalon-mm register slave
//
// Operation
// - while not transmitting, watch rx input for a falling edge as possible start
// - after the edge let one bit time of eight states pass, then shift bits
// - received ninth bit overwrites the ninth-bit control bit
// - after nine bits wait one stop bit time, then move character into buffer
// - set receiver-ready when buffer loads; interrupt if receive interrupt enabled
// - transmit start during reception abandons reception
// - baud code 0..6 divides clock by 6656..208; code 7 reserved
// - baud code change takes effect immediately, even mid-character
// - data register write loads shifter, starts transmission, clears transmitter-empty
// - data register read returns receive buffer; no read-modify-write
// - receiver-ready clears on written zero; written one sets it and interrupts
// - transmitter-empty sets after full character sent; clears on zero or data write
// - receive interrupt enable gates receive interrupt, leaves flag alone
// - transmit interrupt enable gates transmit interrupt, leaves flag alone
// - control bit 0 gives transmitted ninth bit; reads back received ninth bit
// - divided clock is eight per bit; bits decided by two-of-three vote
// - frame is low start, eight data lsb first, ninth bit, high stop
// - serial output is inverted at the pin
//
// Added by the designer: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "uart_hd_map.vh"
module uart_hd (
  input  wire        core_clk,            // 50 MHz clock
  input  wire        rst,                 // async reset, active high
  input  wire [9:0]  avs_address,         // byte address
  input  wire        avs_read,            // read request
  input  wire        avs_write,           // write request
  input  wire [31:0] avs_writedata,       // write data
  input  wire [3:0]  avs_byteenable,      // byte lanes
  output reg  [31:0] avs_readdata,        // read data, registered
  output wire        avs_waitrequest,     // stall until answer phase
  input  wire        rx_in,               // serial receive line
  output reg         tx_pin_n,            // inverted serial output
  output reg         serial_output_select,// high while uart owns tx pin
  output wire        irq                  // level interrupt
);
  localparam S_IDLE = 2'd0;
  localparam S_RX   = 2'd1;
  localparam S_TX   = 2'd2;

  reg  [7:0]  ctrl_q;
  reg  [7:0]  rx_buf_q;
  reg  [2:0]  ev_stat_q;
  reg  [2:0]  ev_en_q;
  reg  [1:0]  state_q;
  reg  [12:0] div_q;
  reg  [2:0]  phase_q;
  reg  [3:0]  bitn_q;
  reg  [9:0]  shift_q;
  reg  [8:0]  tx_q;
  reg  [2:0]  vote_q;
  reg         rx_prev_q;
  reg         ack_q;

  // bit time divided by eight gives one state length
  function [12:0] state_len;
    input [2:0] code;
    begin
      case (code)
        3'd0: state_len = `DIV_0 >> 3;
        3'd1: state_len = `DIV_1 >> 3;
        3'd2: state_len = `DIV_2 >> 3;
        3'd3: state_len = `DIV_3 >> 3;
        3'd4: state_len = `DIV_4 >> 3;
        3'd5: state_len = `DIV_5 >> 3;
        default: state_len = `DIV_6 >> 3; // reserved code runs at the fastest rate
      endcase
    end
  endfunction

  // two-of-three majority
  function maj3;
    input [2:0] v;
    begin
      maj3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
    end
  endfunction

  // line level to pin level; the pin is inverted so one transistor can buffer it
  function line_to_pin;
    input line;
    begin
      line_to_pin = ~line;
    end
  endfunction

  // match of one register index against the full byte address
  function reg_hit;
    input [9:0] addr;
    input [7:0] idx;
    begin
      reg_hit = (addr == {idx, 2'b00});
    end
  endfunction

  // bus decode; one wait cycle then the answer edge
  // the stall gives the read mux a whole cycle, so software sees one fixed latency
  wire        req      = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_q;
  wire        wr0      = avs_write & ack_q & avs_byteenable[0];
  wire [7:0]  wd       = avs_writedata[7:0];
  wire        hit_data = reg_hit(avs_address, `DATA_PORT_IDX);
  wire        hit_ctrl = reg_hit(avs_address, `CTRL_STAT_IDX);
  wire        hit_stat = reg_hit(avs_address, `IRQ_STATUS_IDX);
  wire        hit_en   = reg_hit(avs_address, `IRQ_ENABLE_IDX);
  wire        hit_clr  = reg_hit(avs_address, `IRQ_CLEAR_IDX);
  wire        tx_start = wr0 & hit_data;
  wire        ctrl_wr  = wr0 & hit_ctrl;

  // state tick: eight ticks per bit time; baud code read live
  wire [12:0] len      = state_len(ctrl_q[`BAUD_MSB:`BAUD_LSB]);
  wire        tick     = (div_q >= len - 13'd1);
  wire        bit_end  = tick && phase_q == `STATES_PER_BIT;
  wire [2:0]  votes    = {vote_q[1:0], rx_in};
  wire        rx_bit   = maj3(vote_q);
  wire        rx_edge  = state_q == S_IDLE && rx_prev_q && !rx_in;
  wire        rx_last  = state_q == S_RX && bit_end && bitn_q == `FRAME_LAST_SLOT;
  wire        rx_done  = rx_last && !tx_start;
  wire        tx_done  = state_q == S_TX && bit_end && bitn_q == `FRAME_LAST_SLOT;
  wire        rx_abort = state_q == S_RX && tx_start;

  // avalon handshake ack
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  reg  [31:0] rdata_d;

  // read mux; unmapped addresses and unused bits read zero
  always @* begin
    rdata_d = 32'h0000_0000;
    if (hit_data)
      rdata_d[7:0] = rx_buf_q;
    else if (hit_ctrl)
      rdata_d[7:0] = ctrl_q;
    else if (hit_stat)
      rdata_d[2:0] = ev_stat_q;
    else if (hit_en)
      rdata_d[2:0] = ev_en_q;
  end

  // read data taken in the stall cycle and held until the next read
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read & ~ack_q) begin
      avs_readdata <= rdata_d;
    end
  end

  reg  [12:0] div_d;
  reg  [2:0]  phase_d;

  // divider next value; comparing against at least the length keeps a baud
  // change mid-count from running the counter past its end
  always @* begin
    div_d   = div_q + 13'd1;
    phase_d = phase_q;
    if (tx_start || rx_edge) begin
      div_d   = 13'h0000;
      phase_d = 3'h0;
    end else if (tick) begin
      div_d   = 13'h0000;
      phase_d = phase_q + 3'd1;
    end
  end

  // divider and state counter; restart aligned on frame starts
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      div_q   <= 13'h0000;
      phase_q <= 3'h0;
    end else begin
      div_q   <= div_d;
      phase_q <= phase_d;
    end
  end

  reg  [1:0]  state_d;
  reg  [3:0]  bitn_d;

  // frame sequencer: receive and transmit share the divider and bit counter, not the shifter
  always @* begin
    state_d = state_q;
    bitn_d  = bitn_q;
    case (state_q)
      S_IDLE: begin
        if (rx_edge) begin
          state_d = S_RX;
          bitn_d  = 4'h0;
        end
      end
      S_RX: begin
        if (bit_end) begin
          bitn_d = bitn_q + 4'd1;
          if (bitn_q == `FRAME_LAST_SLOT)
            state_d = S_IDLE;
        end
      end
      S_TX: begin
        if (bit_end) begin
          bitn_d = bitn_q + 4'd1;
          if (bitn_q == `FRAME_LAST_SLOT)
            state_d = S_IDLE;
        end
      end
      default: begin
        state_d = S_IDLE;
      end
    endcase
    // transmit has priority; a frame being received is simply dropped
    if (tx_start) begin
      state_d = S_TX;
      bitn_d  = 4'h0;
    end
  end

  // sequencer state and bit slot
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q <= S_IDLE;
      bitn_q  <= 4'h0;
    end else begin
      state_q <= state_d;
      bitn_q  <= bitn_d;
    end
  end

  // line history and vote samples run in every state, so an edge right
  // after a transmit frame is still caught
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_prev_q <= 1'b1;
      vote_q    <= 3'h0;
    end else begin
      rx_prev_q <= rx_in;
      if (tick && (phase_q == `VOTE_A || phase_q == `VOTE_B || phase_q == `VOTE_C))
        vote_q <= votes;
    end
  end

  // receive shifter and buffer; an abandoned frame leaves the buffer alone
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      shift_q  <= 10'h000;
      rx_buf_q <= 8'h00;
    end else if (state_q == S_RX && bit_end && !tx_start) begin
      if (bitn_q >= 4'd1 && bitn_q <= `FRAME_DATA_BITS)
        shift_q <= {rx_bit, shift_q[9:1]};
      if (rx_done)
        rx_buf_q <= shift_q[8:1];
    end
  end

  // transmit shifter: loaded on a data write, one place at the end of each bit slot after the start slot
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_q <= 9'h000;
    end else if (tx_start) begin
      tx_q <= {ctrl_q[`NINTH_BIT], wd};
    end else if (state_q == S_TX && bit_end && bitn_q >= 4'd1) begin
      tx_q <= {1'b1, tx_q[8:1]};
    end
  end

  reg         pin_d;
  reg         sel_d;

  // pin and select next value; the pin rests at line high between frames
  always @* begin
    pin_d = tx_pin_n;
    sel_d = serial_output_select;
    case (state_q)
      S_IDLE: begin
        pin_d = line_to_pin(1'b1);
      end
      S_TX: begin
        sel_d = 1'b1;
        if (bit_end) begin
          if (bitn_q == `NINTH_SLOT)
            pin_d = line_to_pin(1'b1);
          else if (bitn_q == 4'd0)
            pin_d = line_to_pin(tx_q[0]);
          else if (bitn_q < `NINTH_SLOT)
            pin_d = line_to_pin(tx_q[1]);
          if (bitn_q == `FRAME_LAST_SLOT)
            sel_d = 1'b0;
        end
      end
      default: begin
        sel_d = serial_output_select;
      end
    endcase
    // a data write always restarts a transmit frame with a start bit
    if (tx_start) begin
      pin_d = line_to_pin(1'b0);
      sel_d = 1'b1;
    end
  end

  // pin and select flip-flops; the pin never glitches between states
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_pin_n             <= 1'b0;
      serial_output_select <= 1'b0;
    end else begin
      tx_pin_n             <= pin_d;
      serial_output_select <= sel_d;
    end
  end

  reg  [7:0]  ctrl_d;

  // control next value; link events come after the software write, so a
  // flag set in the same cycle as a write is never lost
  always @* begin
    ctrl_d = ctrl_q;
    if (ctrl_wr) begin
      ctrl_d[`RX_READY_BIT]       = wd[`RX_READY_BIT];
      ctrl_d[`TX_EMPTY_BIT]       = wd[`TX_EMPTY_BIT];
      ctrl_d[`RX_IRQ_EN_BIT]      = wd[`RX_IRQ_EN_BIT];
      ctrl_d[`TX_IRQ_EN_BIT]      = wd[`TX_IRQ_EN_BIT];
      ctrl_d[`BAUD_MSB:`BAUD_LSB] = wd[`BAUD_MSB:`BAUD_LSB];
      ctrl_d[`NINTH_BIT]          = wd[`NINTH_BIT];
    end
    if (tx_start)
      ctrl_d[`TX_EMPTY_BIT] = 1'b0;
    if (rx_done) begin
      ctrl_d[`RX_READY_BIT] = 1'b1;
      ctrl_d[`NINTH_BIT]    = shift_q[9];
    end
    if (tx_done)
      ctrl_d[`TX_EMPTY_BIT] = 1'b1;
  end

  // control register: flags, enables, baud code, ninth bit
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= `CTRL_RESET;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  reg  [2:0]  ev_stat_d;
  reg  [2:0]  ev_en_d;
  wire [2:0]  ev_set   = {rx_abort, tx_done, rx_done};

  // write-one clear first, then new events: set wins over a clear
  always @* begin
    ev_stat_d = ev_stat_q;
    ev_en_d   = ev_en_q;
    if (wr0 & hit_clr)
      ev_stat_d = ev_stat_d & ~wd[2:0];
    ev_stat_d = ev_stat_d | ev_set;
    if (wr0 & hit_en)
      ev_en_d = wd[2:0];
  end

  // sticky event status and its enables
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ev_stat_q <= 3'h0;
      ev_en_q   <= 3'h0;
    end else begin
      ev_stat_q <= ev_stat_d;
      ev_en_q   <= ev_en_d;
    end
  end

  // interrupt: control flags gated by their enables, plus event status gated by event enables
  assign irq = (ctrl_q[`RX_READY_BIT] & ctrl_q[`RX_IRQ_EN_BIT])
             | (ctrl_q[`TX_EMPTY_BIT] & ctrl_q[`TX_IRQ_EN_BIT])
             | |(ev_stat_q & ev_en_q);
endmodule
`default_nettype wire

/* File: tb/uart_hd_asserts.sv */
// port assertions for the half-duplex uart
`timescale 1ns/1ps
`default_nettype none
module uart_hd_asserts (
  input wire logic        core_clk,             // clock
  input wire logic        rst,                  // reset
  input wire logic [9:0]  avs_address,          // address
  input wire logic        avs_read,             // read
  input wire logic        avs_write,            // write
  input wire logic [3:0]  avs_byteenable,       // lanes
  input wire logic [31:0] avs_readdata,         // read data
  input wire logic        avs_waitrequest,      // stall
  input wire logic        tx_pin_n,             // serial out
  input wire logic        serial_output_select, // tx owns pin
  input wire logic        irq                   // interrupt
);
  localparam int MAXF = 73220;
  logic [16:0] busy_q;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // length of the frame in progress, code 0 is the slowest
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) busy_q <= 17'h0;
    else busy_q <= serial_output_select ? busy_q + 17'h1 : 17'h0;
  end
  sequence s_taken;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence
  sequence s_tx_write;
    avs_write && !avs_waitrequest && avs_byteenable[0] && avs_address == 10'h358;
  endsequence
  AST_WAIT_ONE: assert property ($rose(avs_read || avs_write) |-> s_taken)
    else $error("request not answered after one wait cycle");
  AST_READ_UPPER: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("upper read data not zero");
  AST_READ_HOLD: assert property (!$past(avs_read) |-> $stable(avs_readdata))
    else $error("read data moved without a read");
  AST_TX_START: assert property (s_tx_write |-> ##[1:4] serial_output_select)
    else $error("data write did not start a frame");
  AST_IDLE_LINE: assert property (!serial_output_select |-> !tx_pin_n)
    else $error("idle output not at line high");
  AST_START_BIT: assert property ($rose(serial_output_select) |-> ##[0:2] tx_pin_n)
    else $error("no start bit");
  AST_STOP_BIT: assert property ($fell(serial_output_select) |-> !$past(tx_pin_n))
    else $error("frame ended without stop level");
  AST_TX_BOUND: assert property (busy_q < MAXF)
    else $error("frame longer than slowest divisor allows");
  AST_IRQ_RESET: assert property ($fell(rst) |-> !irq && !serial_output_select)
    else $error("interrupt or transmit active after reset");
endmodule
bind uart_hd uart_hd_asserts chk_i (
  .core_clk(core_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .tx_pin_n(tx_pin_n),
  .serial_output_select(serial_output_select), .irq(irq));
`default_nettype wire

/* File: tb/remote_uart.sv */
// remote serial transceiver on the uart lines
`timescale 1ns/1ps
`default_nettype none
module remote_uart (
  input  wire logic core_clk, // clock
  input  wire logic tx_pin_n, // inverted uart output
  input  wire logic tx_on,    // uart owns its pin
  output var  logic rx_line   // line into the uart
);
  // idle line rests high, as with a pull-up
  initial rx_line = 1'b1;
  // low start, nine bits lsb first, high stop
  task automatic send(input logic [8:0] d, input int bt);
    logic [10:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      rx_line <= f[i];
      repeat (bt) @(posedge core_clk);
    end
  endtask
  // bit time comes from bt, start length is only measured into lo; sampling mid-bit tolerates skew
  task automatic get(input int bt, output logic [9:0] d, output int lo);
    lo = 0;
    do @(negedge core_clk); while (!(tx_on && tx_pin_n));
    while (tx_pin_n) begin
      lo++;
      @(negedge core_clk);
    end
    repeat (bt / 2) @(negedge core_clk);
    for (int i = 0; i < 10; i++) begin
      d[i] = ~tx_pin_n | ~tx_on;
      repeat (bt) @(negedge core_clk);
    end
  endtask
endmodule
`default_nettype wire

/* File: tb/test_uart_hd.sv */
// self-checking bench for the half-duplex uart
`timescale 1ns/1ps
`default_nettype none
module test_uart_hd;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic [9:0]  avs_address = 10'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  be = 4'h1;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest, rx_in, tx_pin_n, tx_on, irq;
  logic [9:0]  fr;
  logic [7:0]  rv;
  int          num_errors = 0, n_checks = 0, lo;
  int          dv[7] = '{6656, 3328, 1664, 832, 416, 256, 208};
  always #10 core_clk = ~core_clk;
  uart_hd uut (.core_clk(core_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(be), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .rx_in(rx_in), .tx_pin_n(tx_pin_n), .serial_output_select(tx_on), .irq(irq));
  remote_uart m (.core_clk(core_clk), .tx_pin_n(tx_pin_n), .tx_on(tx_on), .rx_line(rx_in));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one transfer, held until waitrequest is seen low
  task automatic acc(input logic w, input logic [9:0] a, input logic [7:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= w;
    avs_read <= ~w;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    rv = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic rchk(input logic [9:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    chk({24'h0, rv}, {24'h0, e});
  endtask
  task automatic ichk(input logic e);
    @(negedge core_clk);
    chk({31'h0, irq}, {31'h0, e});
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // tests need about 16k cycles
  initial begin
    repeat (60000) @(posedge core_clk);
    num_errors++;
    conclude();
  end
  initial begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    rchk(10'h35c, 8'h00);
    rchk(10'h000, 8'h00);
    be <= 4'h0;
    acc(1'b1, 10'h35c, 8'h0c);
    be <= 4'h1;
    rchk(10'h35c, 8'h00);
    $display("reset test done");
    acc(1'b1, 10'h35c, 8'h0c);
    m.send(9'h1a5, 208);
    repeat (40) @(posedge core_clk);
    rchk(10'h358, 8'ha5);
    rchk(10'h35c, 8'h8d);
    ichk(1'b0);
    acc(1'b1, 10'h35c, 8'hac);
    ichk(1'b1);
    acc(1'b1, 10'h35c, 8'h2c);
    ichk(1'b0);
    acc(1'b1, 10'h35c, 8'hac);
    ichk(1'b1);
    acc(1'b1, 10'h35c, 8'h0c);
    ichk(1'b0);
    $display("receive test done");
    for (int c = 4; c < 7; c++) begin
      acc(1'b1, 10'h35c, {4'h0, c[2:0], 1'b1});
      acc(1'b1, 10'h358, 8'h55);
      m.get(dv[c], fr, lo);
      chk({22'h0, fr}, 32'h355);
      chk(lo, dv[c]);
      rchk(10'h35c, {4'h4, c[2:0], 1'b1});
    end
    $display("transmit test done");
    acc(1'b1, 10'h35c, 8'h5d);
    ichk(1'b1);
    acc(1'b1, 10'h35c, 8'h4d);
    ichk(1'b0);
    fork
      m.send(9'h0f0, 208);
    join_none
    repeat (600) @(posedge core_clk);
    acc(1'b1, 10'h358, 8'h55);
    rchk(10'h35c, 8'h0d);
    m.get(208, fr, lo);
    chk({22'h0, fr}, 32'h355);
    repeat (300) @(posedge core_clk);
    rchk(10'h358, 8'ha5);
    rchk(10'h35c, 8'h4d);
    $display("abort test done");
    rchk(10'h360, 8'h07);
    acc(1'b1, 10'h364, 8'h04);
    ichk(1'b1);
    acc(1'b1, 10'h364, 8'h00);
    ichk(1'b0);
    acc(1'b1, 10'h364, 8'h07);
    acc(1'b1, 10'h368, 8'h07);
    rchk(10'h360, 8'h00);
    ichk(1'b0);
    $display("event test done");
    conclude();
  end
endmodule
`default_nettype wire
